// [core/wps_pkg.sv]
// wps_pkg: constants and types for the watchdog and power-save controller
// assumes a 32-bit apb slave at 25 mhz; one clock domain
package wps_pkg;
   // ==========================================
   // register map (byte addresses)
   localparam logic [7:0] WPS_OFS_CMP = 8'h00;
   localparam logic [7:0] WPS_OFS_CKC = 8'h04;
   localparam logic [7:0] WPS_OFS_STAT = 8'h08;
   localparam logic [7:0] WPS_OFS_CMD = 8'h0c;
   // ==========================================
   // field positions
   localparam int WPS_CMP_CLR_BIT = 7;
   localparam int WPS_CKC_RC_BIT = 0;
   localparam int WPS_CKC_RST_BIT = 1;
   localparam int WPS_CKC_WAKE_BIT = 2;
   localparam int WPS_CMD_STOP_BIT = 0;
   localparam int WPS_CMD_FLAGCLR_BIT = 1;
   // ==========================================
   // reset values
   localparam logic [7:0] WPS_CMP_RST = 8'h7f;
   localparam logic [7:0] WPS_CKC_RST = 8'h00;
   // ==========================================
   // timing: wake counter runs 00..ff, rc prescale 2^8
   localparam logic [7:0] WPS_STAB_LAST = 8'hff;
   localparam int WPS_RC_PRE_W = 8;
   localparam int WPS_BIT_PERIOD_NS = 40;
   localparam int WPS_CLK_NS = 40;
   localparam int WPS_BIT_CYC = (WPS_BIT_PERIOD_NS + WPS_CLK_NS - 1) / WPS_CLK_NS;
   // ==========================================
   // power states
   typedef enum logic [3:0] {
      WPS_RUN = 4'b0001,
      WPS_STOP = 4'b0010,
      WPS_WAKET = 4'b0100,
      WPS_STAB = 4'b1000
   } wps_state_t;
   // wake sources bundled
   typedef struct packed {
      logic [3:0] ext_irq;
      logic [1:0] event_cnt;
      logic serial;
      logic timer0;
      logic timer2;
   } wps_wake_t;
endpackage

// [core/wps_wdcnt.sv]
// wps_wdcnt: 7-bit watchdog counter with compare and clear
// assumes tick is a single-cycle pulse in the pclk domain
`timescale 1ns/100ps
module wps_wdcnt
   import wps_pkg::*;
#(
   parameter int WIDTH = 7
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic clear,
   input wire logic [WIDTH-1:0] limit,
   output logic match
);
   logic [WIDTH-1:0] cnt_reg;
   // ==========================================
   // counter, zero on reset and clear
   // RL5 clear zeroes counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
         match <= 1'b0;
      end else if (clear) begin
         cnt_reg <= '0;
         match <= 1'b0;
      end else if (tick) begin
         // RL3 compare with limit
         if (cnt_reg + 1'b1 == limit) begin
            cnt_reg <= '0;
            match <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
            match <= 1'b0;
         end
      end else begin
         match <= 1'b0;
      end
   end
endmodule

// [core/wps_ctrl.sv]
// wps_ctrl: watchdog timer and stop / wake-up-timer power-save control
// assumes apb master on pclk; rc and interval ticks are pclk-synchronous pulses
//
// Operation
// RL1: watchdog ticks from rc oscillator or prescaled system clock.
// RL2: rc source keeps counting while main oscillator halted, stop included.
// RL3: 7-bit counter compared to compare bits 6..0 sets match flag.
// RL4: match raises interrupt or resets cpu per reset-select bit.
// RL5: counter-clear bit zeroes counter, self-clears after one cycle.
// RL6: counting starts only after interval timer cleared.
// RL7: rc timeout is period*256*compare plus half of period*256; code times out at exactly period*256*compare after a clear.
// RL8: interval-timer source makes plain 7-bit interval timer.
// RL9: rc-source select bit switches watchdog to rc oscillator.
// RL10: stop enters stop mode or wake-up-timer mode per wake select.
// RL11: stop halts oscillator, cpu, prescaler, timers; state retained.
// RL12: wake-timer mode keeps oscillator; timers 0 and 2 on div-2048.
// RL13: stop exits by reset, rc watchdog, ext, event, serial; plus timers.
// RL14: program counter holds address following stop instruction.
// RL15: software writes clock control register as whole bytes only.
// RL16: software places two nops after each stop.
// RL17: reset held long enough for oscillator restart.
// RL18: wake with master enable takes interrupt, else resumes without vector.
// RL19: wake from stop waits for interval counter overflow from zero.
// RL20: wake-timer exit inserts no stabilization delay.
// RL21: match flag sticky until accepted or cleared; counter zero after reset.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/100ps
module wps_ctrl
   import wps_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rc_tick,
   input wire logic bit_tick,
   input wire logic bit_clear,
   input wire logic irq_accept,
   input wire logic master_irq_en,
   input wire wps_wake_t wake_src,
   input wire logic [15:0] next_pc,
   output logic wd_irq,
   output logic cpu_reset,
   output logic osc_run,
   output logic cpu_run,
   output logic timers_run,
   output logic presc_2048_only,
   output logic wake_vector,
   output logic [15:0] held_pc
);
   logic [7:0] cmp_reg;
   logic [7:0] ckc_reg;
   logic flag_reg;
   logic started_reg;
   logic [7:0] stab_reg;
   logic [WPS_RC_PRE_W-1:0] rc_pre_reg;
   wps_state_t state_reg;
   logic wr;
   logic rd;
   logic match;
   logic wd_tick;
   logic stop_cmd;
   logic flag_clr;
   logic wake_any;

   // ==========================================
   // apb decode, zero-wait
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign stop_cmd = wr && hit(paddr, WPS_OFS_CMD) && pwdata[WPS_CMD_STOP_BIT];
   assign flag_clr = wr && hit(paddr, WPS_OFS_CMD) && pwdata[WPS_CMD_FLAGCLR_BIT];

   // register writes; clear bit self-clears next cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_reg <= WPS_CMP_RST;
         ckc_reg <= WPS_CKC_RST;
      end else begin
         // RL5 self-clearing clear bit
         cmp_reg[WPS_CMP_CLR_BIT] <= 1'b0;
         if (wr && hit(paddr, WPS_OFS_CMP)) begin
            cmp_reg <= pwdata[7:0];
         end else if (wr && hit(paddr, WPS_OFS_CKC)) begin
            // RL9 rc select byte write
            ckc_reg <= pwdata[7:0];
         end
      end
   end

   // read data and response
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !(hit(paddr, WPS_OFS_CMP) || hit(paddr, WPS_OFS_CKC)
                    || hit(paddr, WPS_OFS_STAT) || hit(paddr, WPS_OFS_CMD));
         if (rd) begin
            if (hit(paddr, WPS_OFS_CMP)) begin
               prdata <= {24'h000000, cmp_reg};
            end else if (hit(paddr, WPS_OFS_CKC)) begin
               prdata <= {24'h000000, ckc_reg};
            end else if (hit(paddr, WPS_OFS_STAT)) begin
               prdata <= {24'h000000, state_reg, 2'b00, started_reg, flag_reg};
            end else begin
               prdata <= '0;
            end
         end
      end
   end

   // ==========================================
   // watchdog clock selection
   // RL6 start after interval clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         started_reg <= 1'b0;
      end else if (bit_clear) begin
         started_reg <= 1'b1;
      end
   end

   // RL7 rc prescale by 2^8
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rc_pre_reg <= '0;
      end else if (cmp_reg[WPS_CMP_CLR_BIT]) begin
         rc_pre_reg <= '0;
      end else if (rc_tick) begin
         rc_pre_reg <= rc_pre_reg + 1'b1;
      end
   end

   // RL1 source mux; RL2 rc runs in every state; RL8 interval source
   assign wd_tick = started_reg && (ckc_reg[WPS_CKC_RC_BIT]
      ? (rc_tick && rc_pre_reg == {WPS_RC_PRE_W{1'b1}})
      : (bit_tick && state_reg == WPS_RUN));

   wps_wdcnt #(
      .WIDTH(7)
   ) u_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .tick(wd_tick),
      .clear(cmp_reg[WPS_CMP_CLR_BIT]),
      .limit(cmp_reg[6:0]),
      .match(match)
   );

   // ==========================================
   // sticky match flag; set beats clear
   // RL21 sticky flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_reg <= 1'b0;
      end else if (match) begin
         flag_reg <= 1'b1;
      end else if (irq_accept || flag_clr) begin
         flag_reg <= 1'b0;
      end
   end

   // RL4 interrupt or reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_irq <= 1'b0;
         cpu_reset <= 1'b0;
      end else begin
         wd_irq <= (flag_reg || match) && !ckc_reg[WPS_CKC_RST_BIT];
         cpu_reset <= match && ckc_reg[WPS_CKC_RST_BIT];
      end
   end

   // ==========================================
   // power-save state machine
   // RL13 wake sources
   assign wake_any = (|wake_src.ext_irq) || (|wake_src.event_cnt) || wake_src.serial
      || (match && ckc_reg[WPS_CKC_RC_BIT])
      || (state_reg == WPS_WAKET && (wake_src.timer0 || wake_src.timer2));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= WPS_RUN;
         stab_reg <= '0;
         wake_vector <= 1'b0;
         held_pc <= '0;
      end else begin
         wake_vector <= 1'b0;
         case (state_reg)
            WPS_RUN: begin
               if (stop_cmd) begin
                  // RL14 hold next address
                  held_pc <= next_pc;
                  // RL10 mode from wake select
                  state_reg <= ckc_reg[WPS_CKC_WAKE_BIT] ? WPS_WAKET : WPS_STOP;
               end
            end
            WPS_STOP: begin
               if (wake_any) begin
                  // RL19 stabilize from zero
                  stab_reg <= '0;
                  state_reg <= WPS_STAB;
               end
            end
            WPS_WAKET: begin
               if (wake_any) begin
                  // RL20 no stabilization; RL18 vector if enabled
                  wake_vector <= master_irq_en;
                  state_reg <= WPS_RUN;
               end
            end
            WPS_STAB: begin
               if (bit_tick) begin
                  stab_reg <= stab_reg + 1'b1;
                  if (stab_reg == WPS_STAB_LAST) begin
                     // RL18 vector if enabled
                     wake_vector <= master_irq_en;
                     state_reg <= WPS_RUN;
                  end
               end
            end
            default: begin
               state_reg <= WPS_RUN;
            end
         endcase
      end
   end

   // RL11 halts in stop; RL12 wake-timer keeps oscillator and timers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_run <= 1'b1;
         cpu_run <= 1'b1;
         timers_run <= 1'b1;
         presc_2048_only <= 1'b0;
      end else begin
         osc_run <= state_reg != WPS_STOP;
         cpu_run <= state_reg == WPS_RUN;
         timers_run <= state_reg == WPS_RUN || state_reg == WPS_WAKET;
         presc_2048_only <= state_reg == WPS_WAKET;
      end
   end

   // ==========================================
   // checks
   property p_clr_self;
      @(posedge pclk) disable iff (!presetn)
      cmp_reg[WPS_CMP_CLR_BIT] |=> !cmp_reg[WPS_CMP_CLR_BIT] || $past(wr);
   endproperty
   a_clr_self: assert property (p_clr_self) else $error("clear bit stuck"); // RL5

   property p_flag_set;
      @(posedge pclk) disable iff (!presetn)
      match |=> flag_reg;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set"); // RL3

   property p_reset_sel;
      @(posedge pclk) disable iff (!presetn)
      match && ckc_reg[WPS_CKC_RST_BIT] |=> cpu_reset && !wd_irq;
   endproperty
   a_reset_sel: assert property (p_reset_sel) else $error("reset select wrong"); // RL4

   property p_stop_mode;
      @(posedge pclk) disable iff (!presetn)
      state_reg == WPS_RUN && stop_cmd |=> state_reg == (ckc_reg[WPS_CKC_WAKE_BIT] ? WPS_WAKET : WPS_STOP);
   endproperty
   a_stop_mode: assert property (p_stop_mode) else $error("bad stop mode"); // RL10

   property p_stop_halt;
      @(posedge pclk) disable iff (!presetn)
      state_reg == WPS_STOP |=> !osc_run && !cpu_run && !timers_run;
   endproperty
   a_stop_halt: assert property (p_stop_halt) else $error("stop not halted"); // RL11

   property p_waket_run;
      @(posedge pclk) disable iff (!presetn)
      state_reg == WPS_WAKET |=> osc_run && timers_run && presc_2048_only && !cpu_run;
   endproperty
   a_waket_run: assert property (p_waket_run) else $error("wake timer outputs wrong"); // RL12

   property p_no_stab;
      @(posedge pclk) disable iff (!presetn)
      state_reg == WPS_WAKET && wake_any |=> state_reg == WPS_RUN;
   endproperty
   a_no_stab: assert property (p_no_stab) else $error("delay in wake timer exit"); // RL20

   property p_pc_hold;
      @(posedge pclk) disable iff (!presetn)
      state_reg == WPS_RUN && stop_cmd |=> (held_pc == $past(next_pc)) ##1 $stable(held_pc);
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("pc not held"); // RL14

   property p_no_start;
      @(posedge pclk) disable iff (!presetn)
      !started_reg |=> !match;
   endproperty
   a_no_start: assert property (p_no_start) else $error("counted before start"); // RL6
endmodule

// [testbench/watchdog_and_power_save_ctrl_test.sv]
// self-checking bench for wps_ctrl: apb register access, watchdog, power save
// assumes wps_pkg compiled first; bench drives every port of the block itself
`timescale 1ns/100ps
module watchdog_and_power_save_ctrl_test;
   import wps_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, wd_irq, cpu_reset, osc_run, cpu_run, timers_run, presc_2048_only, wake_vector;
   logic rc_tick = 0, bit_tick = 0, bit_clear = 0, irq_accept = 0, master_irq_en = 1;
   wps_wake_t wake_src = '0;
   logic [15:0] next_pc = 16'h0, held_pc, pc;
   logic [33:0] exp_q[$]; // read flag, error, data
   logic [33:0] e;
   int err_count = 0, checks_done = 0, cycles = 0, rst_pulses = 0, wakes = 0, seed = 6;
   logic [7:0] lim;
   wps_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rc_tick(rc_tick), .bit_tick(bit_tick), .bit_clear(bit_clear), .irq_accept(irq_accept),
      .master_irq_en(master_irq_en), .wake_src(wake_src), .next_pc(next_pc), .wd_irq(wd_irq),
      .cpu_reset(cpu_reset), .osc_run(osc_run), .cpu_run(cpu_run), .timers_run(timers_run),
      .presc_2048_only(presc_2048_only), .wake_vector(wake_vector), .held_pc(held_pc));
   // ==========================================
   // clock, timeout and pulse counters
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cpu_reset === 1'b1) rst_pulses++;
      if (wake_vector === 1'b1) wakes++;
      if (cycles == 20000) begin
         err_count++;
         results();
      end
   end
   // ==========================================
   // tasks
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // apb transfer: setup, access held until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] x);
      exp_q.push_back(x);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1, a, d, 34'h0);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] d);
      apb(0, a, 32'h0, {2'b10, d});
   endtask
   task waitc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task ticks(input int n, input logic rc);
      repeat (n) begin
         @(posedge pclk);
         if (rc) rc_tick <= 1;
         else bit_tick <= 1;
         @(posedge pclk);
         rc_tick <= 0;
         bit_tick <= 0;
      end
      waitc(3);
   endtask
   task done(input string s);
      $display("test %s finished", s);
   endtask
   // ==========================================
   // monitor: oldest note against each completed transfer
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         if (exp_q.size() == 0) check(32'h0, 32'h1);
         else begin
            e = exp_q.pop_front();
            check({31'h0, pslverr}, {31'h0, e[32]});
            if (e[33]) check(prdata, e[31:0]);
         end
      end
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      lim = 8'd3 + 8'($random(seed) & 7);
      // reset values and unmapped access
      rd(WPS_OFS_CMP, {24'h0, WPS_CMP_RST});
      rd(WPS_OFS_CKC, {24'h0, WPS_CKC_RST});
      rd(WPS_OFS_STAT, 32'h10);
      apb(0, 8'h10, 32'h0, {2'b11, 32'h0});
      apb(1, 8'h14, 32'hff, {2'b01, 32'h0});
      done("reset");
      // count to compare on interval ticks
      wr(WPS_OFS_CMP, {24'h0, lim});
      ticks(1, 0);
      rd(WPS_OFS_STAT, 32'h10);
      @(posedge pclk) bit_clear <= 1;
      @(posedge pclk) bit_clear <= 0;
      ticks(lim - 1, 0);
      rd(WPS_OFS_STAT, 32'h12);
      ticks(1, 0);
      rd(WPS_OFS_STAT, 32'h13);
      check({31'h0, wd_irq}, 32'h1);
      ticks(1, 0);
      check({31'h0, wd_irq}, 32'h1);
      @(posedge pclk) irq_accept <= 1;
      @(posedge pclk) irq_accept <= 0;
      waitc(2);
      check({31'h0, wd_irq}, 32'h0);
      done("interval");
      ticks(lim - 2, 0);
      wr(WPS_OFS_CMP, {24'h0, 8'h80 | lim});
      rd(WPS_OFS_CMP, {24'h0, lim});
      ticks(lim - 1, 0);
      rd(WPS_OFS_STAT, 32'h12);
      ticks(1, 0);
      rd(WPS_OFS_STAT, 32'h13);
      wr(WPS_OFS_CMD, 32'h2);
      rd(WPS_OFS_STAT, 32'h12);
      done("clear");
      // reset-select gives one cpu reset pulse
      wr(WPS_OFS_CKC, 32'h2);
      ticks(lim, 0);
      check(32'(rst_pulses), 32'h1);
      check({31'h0, wd_irq}, 32'h0);
      wr(WPS_OFS_CMD, 32'h2);
      done("reset select");
      wr(WPS_OFS_CKC, 32'h1);
      ticks(256 * (lim - 1), 1);
      rd(WPS_OFS_STAT, 32'h12);
      ticks(256, 1);
      rd(WPS_OFS_STAT, 32'h13);
      wr(WPS_OFS_CMD, 32'h2);
      done("rc source");
      wr(WPS_OFS_CKC, 32'h0);
      pc = 16'($random(seed));
      next_pc <= pc;
      wr(WPS_OFS_CMD, 32'h1);
      waitc(3);
      check({29'h0, osc_run, cpu_run, timers_run}, 32'h0);
      check({16'h0, held_pc}, {16'h0, pc});
      @(posedge pclk) wake_src.timer0 <= 1;
      @(posedge pclk) wake_src.timer0 <= 0;
      waitc(4);
      check({31'h0, cpu_run}, 32'h0);
      // ext wake, then 256 interval ticks
      @(posedge pclk) wake_src.ext_irq[1] <= 1;
      @(posedge pclk) wake_src.ext_irq[1] <= 0;
      ticks(255, 0);
      check({31'h0, cpu_run}, 32'h0);
      ticks(1, 0);
      check({31'h0, cpu_run}, 32'h1);
      check(32'(wakes), 32'h1);
      done("stop");
      master_irq_en <= 0;
      wr(WPS_OFS_CKC, 32'h4);
      wr(WPS_OFS_CMD, 32'h1);
      waitc(3);
      check({28'h0, osc_run, cpu_run, presc_2048_only, timers_run}, 32'hb);
      @(posedge pclk) wake_src.timer0 <= 1;
      @(posedge pclk) wake_src.timer0 <= 0;
      waitc(3);
      check({30'h0, cpu_run, presc_2048_only}, 32'h2);
      check(32'(wakes), 32'h1);
      done("wake timer");
      results();
   end
endmodule
